// ==== core/tdm_monitor.sv ====
// Purpose: Safe torque disconnect supervision with APB registers
// Assumes: Channel inputs low select disconnection; one 250 MHz clock
// Notes:   Test timer and alarm never influence the restart sequence
// Notes on behaviour
// - Each low channel forces its own pulse suppression output.
// - Selection closes the holding brake when a brake is configured.
// - Single channel select then release within 2 s gives no message.
// - Restart needs both released, enable, run falling then rising.
// - Pin to suppression far below 15 ms or 5 ms worst case.
// - Each select then release counts as a test of both paths.
// - 8760 hour timer; on expiry alarm stays until a path test.
// - Every release reloads the test timer to its set value.
// - Overdue alarm only informs; machine operation is unaffected.
// - Test before expiry resets timer and raises no alarm.
// - Lasting channel disagreement raises a fault and coasts the motor.
// - Brake close output goes low 30 ms after disconnection.
`timescale 1ns/1ps
module tdm_monitor
	import tdm_pkg::*;
#(
	parameter int          MS_CYC  = tdm_pkg::CYC_PER_MS,
	parameter int          WIN_MS  = tdm_pkg::SINGLE_WIN_MS,
	parameter int          BRK_MS  = tdm_pkg::BRAKE_DELAY_MS,
	parameter logic [35:0] TEST_MS = 36'(tdm_pkg::TEST_INTERVAL_MS)
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Terminals
	input  wire logic        safety_channel_a,
	input  wire logic        safety_channel_b,
	input  wire logic        run_command,
	// Power stage and brake
	output logic             pulse_suppress_a,
	output logic             pulse_suppress_b,
	output logic             coast_stop,
	output logic             motor_run_enable,
	output logic             brake_hold_open,
	// Interrupt
	output logic             irq
);
	import tdm_pkg::*;

	// Parameter checks
	if (MS_CYC < 1 || WIN_MS < 2 || BRK_MS < 1 || TEST_MS < 36'h2) begin
		$error("tdm_monitor: time parameter out of range");
	end

	// Synchronised pins
	logic chan_a;
	logic chan_b;
	logic run_s;
	tdm_sync #(.W(3)) u_sync (
		.clock (clock),
		.rst   (rst),
		.d     ({safety_channel_a, safety_channel_b, run_command}),
		.q     ({chan_a, chan_b, run_s})
	);

	function automatic logic [31:0] cnt_up(input logic [31:0] c,
		input logic [31:0] lim);
		cnt_up = (c < lim) ? c + 32'h0000_0001 : c;
	endfunction

	// State registers
	logic [31:0]   div_reg, div_next;
	logic          tick_reg, tick_next;
	tdm_state_type state_reg, state_next;
	logic          run_prev_reg, run_prev_next;
	logic          sel_reg, sel_next;
	logic [31:0]   disc_reg, disc_next;
	logic          fault_reg, fault_next;
	logic [31:0]   brk_reg, brk_next;
	logic          brake_reg, brake_next;
	logic          pa_reg, pa_next;
	logic          pb_reg, pb_next;
	logic          run_reg, run_next;
	logic [35:0]   test_reg, test_next;
	logic          alarm_reg, alarm_next;
	tdm_ctrl_type  ctrl_reg, ctrl_next;
	tdm_event_type stat_reg, stat_next;
	tdm_event_type mask_reg, mask_next;
	logic          irq_reg, irq_next;
	logic          rdy_reg, rdy_next;
	logic          err_reg, err_next;
	logic [31:0]   rd_reg, rd_next;

	logic          sel_now;
	logic          deselect_ev;
	tdm_event_type ev;
	tdm_status_type status;

	assign sel_now     = !chan_a || !chan_b;
	assign deselect_ev = sel_reg && !sel_now;

	// Millisecond enable and safety path next values
	always_comb begin
		div_next      = (div_reg == 32'(MS_CYC - 1)) ? '0 : div_reg + 32'h1;
		tick_next     = (div_reg == 32'(MS_CYC - 1));
		sel_next      = sel_now;
		run_prev_next = run_s;
		pa_next       = !chan_a;
		pb_next       = !chan_b;
		// Disagreement must last the window before it counts
		disc_next     = (chan_a == chan_b) ? '0 :
			(tick_reg ? cnt_up(disc_reg, 32'(WIN_MS)) : disc_reg);
		fault_next    = fault_reg;
		if (chan_a == chan_b) begin
			fault_next = 1'b0;
		end else if (tick_reg && disc_reg == 32'(WIN_MS - 1)) begin
			fault_next = 1'b1;
		end
		// Brake closes a fixed delay after selection
		brk_next   = !sel_now ? '0 :
			(tick_reg ? cnt_up(brk_reg, 32'(BRK_MS)) : brk_reg);
		brake_next = brake_reg;
		if (!ctrl_reg.brake_cfg) begin
			brake_next = 1'b0;
		end else if (sel_reg && brk_reg == 32'(BRK_MS)) begin
			brake_next = 1'b0;
		end else if (state_reg == ST_RUN) begin
			brake_next = 1'b1;
		end
		// Restart sequence; alarm is not an input here
		state_next = state_reg;
		case (state_reg)
			ST_SAFE: begin
				if (!sel_now) state_next = ST_WAIT_EN;
			end
			ST_WAIT_EN: begin
				if (ctrl_reg.drive_en) state_next = ST_WAIT_FALL;
			end
			ST_WAIT_FALL: begin
				if (run_prev_reg && !run_s) state_next = ST_WAIT_RISE;
			end
			ST_WAIT_RISE: begin
				if (!run_prev_reg && run_s) state_next = ST_RUN;
			end
			ST_RUN: begin
				if (run_prev_reg && !run_s) state_next = ST_WAIT_RISE;
			end
			default: begin
				state_next = ST_SAFE;
			end
		endcase
		if (state_reg != ST_SAFE && !ctrl_reg.drive_en) begin
			state_next = ST_WAIT_EN;
		end
		if (sel_now || fault_reg) begin
			state_next = ST_SAFE;
		end
		run_next = (state_next == ST_RUN);
	end

	// Safety path registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_reg      <= '0;
			tick_reg     <= 1'b0;
			sel_reg      <= 1'b1;
			run_prev_reg <= 1'b0;
			pa_reg       <= 1'b1;
			pb_reg       <= 1'b1;
			disc_reg     <= '0;
			fault_reg    <= 1'b0;
			brk_reg      <= '0;
			brake_reg    <= 1'b0;
			state_reg    <= ST_SAFE;
			run_reg      <= 1'b0;
		end else begin
			div_reg      <= div_next;
			tick_reg     <= tick_next;
			sel_reg      <= sel_next;
			run_prev_reg <= run_prev_next;
			pa_reg       <= pa_next;
			pb_reg       <= pb_next;
			disc_reg     <= disc_next;
			fault_reg    <= fault_next;
			brk_reg      <= brk_next;
			brake_reg    <= brake_next;
			state_reg    <= state_next;
			run_reg      <= run_next;
		end
	end

	// Path test timer next values
	always_comb begin
		test_next  = test_reg;
		alarm_next = alarm_reg;
		if (deselect_ev) begin
			test_next  = TEST_MS;
			alarm_next = 1'b0;
		end else begin
			if (tick_reg && test_reg != '0) begin
				test_next = test_reg - 36'h1;
			end
			if (test_reg == '0) begin
				alarm_next = 1'b1;
			end
		end
	end

	// Path test timer registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			test_reg  <= TEST_MS;
			alarm_reg <= 1'b0;
		end else begin
			test_reg  <= test_next;
			alarm_reg <= alarm_next;
		end
	end

	// Event sources and status word
	always_comb begin
		ev          = '0;
		ev.select   = !sel_reg && !chan_a && !chan_b;
		ev.deselect = deselect_ev;
		ev.fault    = fault_next && !fault_reg;
		ev.alarm    = alarm_next && !alarm_reg;
		status        = '0;
		status.chan_a = chan_a;
		status.chan_b = chan_b;
		status.sel    = sel_reg;
		status.fault  = fault_reg;
		status.alarm  = alarm_reg;
		status.brake  = brake_reg;
		status.run    = run_reg;
		status.state  = state_reg;
	end

	// APB access, registers and interrupt next values
	always_comb begin
		logic acc;
		logic wr;
		logic hit;
		acc       = psel && penable && !rdy_reg;
		wr        = psel && penable && rdy_reg && pwrite;
		hit       = paddr inside {OFS_CTRL, OFS_STATUS, OFS_IRQ_STAT,
			OFS_IRQ_MASK, OFS_TIMER};
		rdy_next  = acc;
		err_next  = acc && !hit;
		rd_next   = '0;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		stat_next = stat_reg;
		if (acc && !pwrite) begin
			case (paddr)
				OFS_CTRL:     rd_next = ctrl_reg;
				OFS_STATUS:   rd_next = status;
				OFS_IRQ_STAT: rd_next = {28'h0, stat_reg};
				OFS_IRQ_MASK: rd_next = {28'h0, mask_reg};
				OFS_TIMER:    rd_next = test_reg[31:0];
				default:      rd_next = '0;
			endcase
		end
		if (wr && paddr == OFS_CTRL) begin
			ctrl_next      = '0;
			ctrl_next.drive_en  = pwdata[0];
			ctrl_next.brake_cfg = pwdata[1];
		end
		if (wr && paddr == OFS_IRQ_MASK) begin
			mask_next = pwdata[3:0];
		end
		if (wr && paddr == OFS_IRQ_STAT) begin
			stat_next = stat_reg & ~pwdata[3:0];
		end
		// A new event beats a clear in the same cycle
		stat_next = stat_next | ev;
		irq_next  = |(stat_next & mask_next);
	end

	// APB and interrupt registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdy_reg  <= 1'b0;
			err_reg  <= 1'b0;
			rd_reg   <= '0;
			ctrl_reg <= CTRL_RST;
			mask_reg <= MASK_RST;
			stat_reg <= '0;
			irq_reg  <= 1'b0;
		end else begin
			rdy_reg  <= rdy_next;
			err_reg  <= err_next;
			rd_reg   <= rd_next;
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			stat_reg <= stat_next;
			irq_reg  <= irq_next;
		end
	end

	// Outputs straight from flip-flops
	assign prdata           = rd_reg;
	assign pready           = rdy_reg;
	assign pslverr          = err_reg;
	assign pulse_suppress_a = pa_reg;
	assign pulse_suppress_b = pb_reg;
	assign coast_stop       = fault_reg;
	assign motor_run_enable = run_reg;
	assign brake_hold_open  = brake_reg;
	assign irq              = irq_reg;

	// Checks
	property p_chan_a_cut;
		@(posedge clock) disable iff (rst) !chan_a |=> pulse_suppress_a;
	endproperty
	a_chan_a_cut: assert property (p_chan_a_cut)
		else $error("channel a low without suppression");

	property p_chan_b_cut;
		@(posedge clock) disable iff (rst) !chan_b |=> pulse_suppress_b;
	endproperty
	a_chan_b_cut: assert property (p_chan_b_cut)
		else $error("channel b low without suppression");

	property p_resp;
		@(posedge clock) disable iff (rst)
			$fell(chan_a) |-> ##[1:2] (pulse_suppress_a && !motor_run_enable);
	endproperty
	a_resp: assert property (p_resp)
		else $error("suppression response too slow");

	property p_brake;
		@(posedge clock) disable iff (rst)
			(sel_reg && brk_reg == 32'(BRK_MS)) |=> !brake_hold_open;
	endproperty
	a_brake: assert property (p_brake)
		else $error("brake not closed after delay");

	property p_fault_late;
		@(posedge clock) disable iff (rst)
			$rose(coast_stop) |-> $past(disc_reg) == 32'(WIN_MS - 1);
	endproperty
	a_fault_late: assert property (p_fault_late)
		else $error("fault raised before window");

	property p_fault_set;
		@(posedge clock) disable iff (rst)
			(chan_a != chan_b && tick_reg && disc_reg == 32'(WIN_MS - 1))
			|=> coast_stop ##1 !motor_run_enable;
	endproperty
	a_fault_set: assert property (p_fault_set)
		else $error("discrepancy fault missing");

	property p_restart;
		@(posedge clock) disable iff (rst)
			$rose(motor_run_enable) |-> $past(state_reg) == ST_WAIT_RISE
			&& $past(run_s) && !$past(run_prev_reg)
			&& $past(ctrl_reg.drive_en);
	endproperty
	a_restart: assert property (p_restart)
		else $error("run enabled out of sequence");

	property p_reload;
		@(posedge clock) disable iff (rst)
			deselect_ev |=> (test_reg == TEST_MS && !alarm_reg);
	endproperty
	a_reload: assert property (p_reload)
		else $error("test timer not reloaded");

	property p_alarm_hold;
		@(posedge clock) disable iff (rst)
			(alarm_reg && !deselect_ev) |=> alarm_reg;
	endproperty
	a_alarm_hold: assert property (p_alarm_hold)
		else $error("alarm dropped without test");

	property p_alarm_inert;
		@(posedge clock) disable iff (rst)
			(state_reg == ST_RUN && !sel_now && !fault_reg && run_s
			&& run_prev_reg && ctrl_reg.drive_en) |=> state_reg == ST_RUN;
	endproperty
	a_alarm_inert: assert property (p_alarm_inert)
		else $error("run state left without cause");

	c_run: cover property (@(posedge clock) disable iff (rst)
		$rose(motor_run_enable));
	c_fault: cover property (@(posedge clock) disable iff (rst)
		$rose(coast_stop));
	c_alarm: cover property (@(posedge clock) disable iff (rst)
		$rose(alarm_reg));
	c_test: cover property (@(posedge clock) disable iff (rst)
		$rose(sel_reg) ##[1:100] deselect_ev);

endmodule // tdm_monitor

// ==== common/tdm_pkg.sv ====
// Purpose: Shared constants and types of the torque disconnect monitor
// Assumes: 250 MHz system clock, APB register access with 32-bit data
// Notes:   Times are held in their own units; cycle counts derive from them
package tdm_pkg;

	// Clock and time base
	localparam int CLK_HZ          = 250_000_000;
	localparam int MS_PER_S        = 1000;
	localparam int CYC_PER_MS      = CLK_HZ / MS_PER_S;

	// Single channel glitch window before a discrepancy fault, seconds
	localparam int SINGLE_WIN_S    = 2;
	localparam int SINGLE_WIN_MS   = SINGLE_WIN_S * MS_PER_S;

	// Brake close delay after torque disconnection, milliseconds
	localparam int BRAKE_DELAY_MS  = 30;

	// Worst case pin to pulse suppression response, milliseconds
	localparam int RESP_LV_MS      = 15;
	localparam int RESP_HV_MS      = 5;
	localparam int RESP_HV_CYC     = RESP_HV_MS * CYC_PER_MS;

	// Path test interval, hours, and the same in milliseconds
	localparam int          TEST_INTERVAL_H  = 8760;
	localparam longint      TEST_INTERVAL_MS =
		longint'(TEST_INTERVAL_H) * 64'd3600 * longint'(MS_PER_S);
	localparam int          TEST_W           = 36;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFS_TIMER    = 8'h10;

	// Reset values
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [3:0]  MASK_RST    = 4'h0;

	// Control register layout
	typedef struct packed {
		logic [29:0] rsvd;
		logic        brake_cfg;  // Bit 1: holding brake fitted
		logic        drive_en;   // Bit 0: drive enable
	} tdm_ctrl_type;

	// Event bits, same layout in interrupt status and mask
	typedef struct packed {
		logic alarm;     // Bit 3: path test overdue
		logic fault;     // Bit 2: channel discrepancy fault
		logic deselect;  // Bit 1: disconnection released, path tested
		logic select;    // Bit 0: both channels selected
	} tdm_event_type;

	// Restart sequence states
	typedef enum logic [2:0] {
		ST_SAFE      = 3'b000,
		ST_WAIT_EN   = 3'b001,
		ST_WAIT_FALL = 3'b010,
		ST_WAIT_RISE = 3'b011,
		ST_RUN       = 3'b100
	} tdm_state_type;

	// Status register layout
	typedef struct packed {
		logic [21:0]   rsvd;
		tdm_state_type state;    // Bits 9:7
		logic          run;      // Bit 6: motor run enabled
		logic          brake;    // Bit 5: brake held open
		logic          alarm;    // Bit 4: test overdue
		logic          fault;    // Bit 3: discrepancy fault
		logic          sel;      // Bit 2: disconnection selected
		logic          chan_b;   // Bit 1: channel b level
		logic          chan_a;   // Bit 0: channel a level
	} tdm_status_type;

endpackage

// ==== core/tdm_sync.sv ====
// Purpose: Two stage synchroniser for asynchronous pin inputs
// Assumes: Inputs are quasi static levels relative to the clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module tdm_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;

	// Two flip-flops in series
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule // tdm_sync

// ==== dv/tdm_terminal_model.sv ====
// Purpose: Outside safety circuit that drives the terminal pins
// Assumes: Bench gives the wanted levels; slow adds three cycles
// Notes:   Pins start released (high), so nothing is selected at start
`timescale 1ns/1ps
module tdm_terminal_model (
	// Clock
	input  wire logic clock,
	// Wanted levels and pace
	input  wire logic want_a,
	input  wire logic want_b,
	input  wire logic want_run,
	input  wire logic slow,
	// Terminals
	output logic      safety_channel_a,
	output logic      safety_channel_b,
	output logic      run_command
);
	logic [3:0][2:0] pipe_reg;

	// Request history, newest at the bottom
	initial pipe_reg = '1;
	always @(posedge clock) begin
		pipe_reg <= {pipe_reg[2:0], want_a, want_b, want_run};
	end

	// Paths are tested only by moving these pins
	assign {safety_channel_a, safety_channel_b, run_command} =
		slow ? pipe_reg[3] : pipe_reg[0];
endmodule // tdm_terminal_model

// ==== dv/tb_tdm_monitor.sv ====
// Purpose: Self checking bench of the torque disconnect monitor
// Assumes: Shortened ms tick, windows and test interval
// Notes:   Read results are queued by the driver, checked by a monitor
`timescale 1ns/1ps
module tb_tdm_monitor;
	import tdm_pkg::*;
	typedef struct {
		logic [31:0] exp;
		logic [31:0] msk;
		logic        err;
	} tdm_note_type;
	logic        clock = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        want_a = 1;
	logic        want_b = 1;
	logic        want_run = 1;
	logic        slow = 0;
	logic        ch_a;
	logic        ch_b;
	logic        run_cmd;
	logic        sup_a;
	logic        sup_b;
	logic        coast;
	logic        run_en;
	logic        brake;
	logic        irq;
	logic [5:0]  outs;
	logic [31:0] rnd;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cyc = 0;
	tdm_note_type notes[$];
	tdm_note_type note;

	assign outs = {sup_a, sup_b, coast, run_en, brake, irq};

	// Block under test with short counts
	tdm_monitor #(.MS_CYC(4), .WIN_MS(5), .BRK_MS(3), .TEST_MS(36'd50)) DUT (
		.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .safety_channel_a(ch_a),
		.safety_channel_b(ch_b), .run_command(run_cmd),
		.pulse_suppress_a(sup_a), .pulse_suppress_b(sup_b),
		.coast_stop(coast), .motor_run_enable(run_en),
		.brake_hold_open(brake), .irq(irq));

	// Outside safety circuit
	tdm_terminal_model partner (
		.clock(clock), .want_a(want_a), .want_b(want_b),
		.want_run(want_run), .slow(slow), .safety_channel_a(ch_a),
		.safety_channel_b(ch_b), .run_command(run_cmd));

	// Clock, 4 ns period
	always #2 clock = ~clock;

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One APB transfer; the expected answer goes to the queue
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
		logic [31:0] exp, logic [31:0] msk, logic err);
		@(posedge clock);
		notes.push_back('{exp, msk, err});
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask

	task automatic pins(logic a, logic b, logic r, int n);
		@(posedge clock);
		want_a <= a;
		want_b <= b;
		want_run <= r;
		repeat (n) @(posedge clock);
	endtask

	// Monitor takes the oldest note at each completed transfer
	always @(posedge clock) begin
		if ((psel & penable & pready) === 1'b1) begin
			note = notes.pop_front();
			check("prdata", prdata & note.msk, note.exp);
			check("pslverr", 32'(pslverr), 32'(note.err));
		end
	end

	// Hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	initial begin
		rnd = $urandom(63);
		repeat (3) @(posedge clock);
		check("reset outs", 32'(outs), 32'h30);
		repeat (2) @(posedge clock);
		rst <= 0;
		repeat (10) @(posedge clock);
		apb(0, OFS_CTRL, 0, 32'h0, 32'hffffffff, 0);
		apb(0, OFS_IRQ_MASK, 0, 32'h0, 32'hf, 0);
		rnd = $urandom & 32'hf;
		apb(1, OFS_IRQ_MASK, rnd, 0, 0, 0);
		apb(0, OFS_IRQ_MASK, 0, rnd, 32'hf, 0);
		apb(1, OFS_IRQ_MASK, 0, 0, 0, 0);
		apb(0, 8'h14, 0, 32'h0, 32'hffffffff, 1);
		apb(0, OFS_STATUS, 0, 32'h83, 32'h3ff, 0);
		$display("test registers done");
		// Run edges before drive enable are ignored
		pins(1, 1, 0, 6);
		pins(1, 1, 1, 6);
		check("early run", 32'(run_en), 32'h0);
		apb(1, OFS_CTRL, 32'h3, 0, 0, 0);
		apb(0, OFS_STATUS, 0, 32'h100, 32'h380, 0);
		slow <= 1;
		pins(1, 1, 0, 10);
		apb(0, OFS_STATUS, 0, 32'h180, 32'h380, 0);
		pins(1, 1, 1, 10);
		slow <= 0;
		check("run outs", 32'(outs), 32'h06);
		apb(0, OFS_STATUS, 0, 32'h263, 32'h3ef, 0);
		$display("test restart done");
		pins(0, 0, 1, 5);
		check("select outs", 32'(outs), 32'h32);
		repeat (6) @(posedge clock);
		check("brake early", 32'(brake), 32'h1);
		repeat (14) @(posedge clock);
		check("brake closed", 32'(outs), 32'h30);
		apb(0, OFS_STATUS, 0, 32'h004, 32'h3ef, 0);
		apb(1, OFS_IRQ_MASK, 32'h1, 0, 0, 0);
		apb(0, OFS_IRQ_STAT, 0, 32'h1, 32'h1, 0);
		check("irq set", 32'(irq), 32'h1);
		apb(1, OFS_IRQ_STAT, 32'hf, 0, 0, 0);
		repeat (2) @(posedge clock);
		check("irq clear", 32'(irq), 32'h0);
		pins(1, 1, 1, 10);
		$display("test select done");
		apb(1, OFS_IRQ_STAT, 32'hf, 0, 0, 0);
		apb(1, OFS_IRQ_MASK, 32'h5, 0, 0, 0);
		rnd = 5 + $urandom % 6;
		pins(0, 1, 1, 5);
		check("one channel", 32'(outs), 32'h20);
		repeat (rnd - 5) @(posedge clock);
		pins(1, 1, 1, 10);
		check("glitch quiet", 32'(outs), 32'h00);
		pins(1, 0, 1, 40);
		check("discrepancy", 32'(outs), 32'h19);
		apb(0, OFS_IRQ_STAT, 0, 32'h6, 32'h7, 0);
		pins(1, 1, 1, 10);
		check("agree again", 32'(outs), 32'h01);
		$display("test discrepancy done");
		apb(1, OFS_IRQ_STAT, 32'hf, 0, 0, 0);
		apb(1, OFS_IRQ_MASK, 32'h8, 0, 0, 0);
		pins(0, 0, 1, 8);
		pins(1, 1, 1, 120);
		pins(0, 0, 1, 8);
		pins(1, 1, 1, 120);
		apb(0, OFS_STATUS, 0, 32'h0, 32'h10, 0);
		pins(1, 1, 0, 8);
		pins(1, 1, 1, 250);
		apb(0, OFS_STATUS, 0, 32'h270, 32'h3f0, 0);
		check("alarm run", 32'(outs), 32'h07);
		repeat (100) @(posedge clock);
		apb(0, OFS_IRQ_STAT, 0, 32'h8, 32'h8, 0);
		pins(0, 0, 1, 8);
		pins(1, 1, 1, 10);
		apb(0, OFS_STATUS, 0, 32'h0, 32'h10, 0);
		apb(0, OFS_TIMER, 0, 32'h20, 32'hffffffe0, 0);
		apb(1, OFS_IRQ_STAT, 32'hf, 0, 0, 0);
		repeat (2) @(posedge clock);
		check("irq off", 32'(irq), 32'h0);
		$display("test path timer done");
		print_verdict();
	end
endmodule // tb_tdm_monitor
